/* hdl/wdt_core.sv */
// Watchdog timer core with APB register access
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/10ps
module wdt_core (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [wdt_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic halt_mode,
   input wire logic stop_mode,
   input wire logic osc_unstoppable,
   output logic wdt_reset
);
   import wdt_pkg::*;

   wdt_mode_t mode_q;
   wdt_mode_t mode_d;
   wdt_lock_t lock_q;
   wdt_lock_t lock_d;
   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic rst_q;
   logic rst_d;

   logic [31:0] prdata_q;
   logic [31:0] prdata_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;

   logic setup;
   logic wr_acc;
   logic mode_wr;
   logic key_wr;
   logic bitop_wr;
   logic parked;
   logic run;
   logic hold;
   logic count_en;
   logic slow_tick;
   logic fast_tick;
   logic tick;
   logic [CNT_W-1:0] last;
   logic violation;
   logic overflow;
   logic mapped;
   wdt_status_t status;

   // Count sources, frozen together with the counter
   wdt_prescaler #(
      .DIV(SLOW_DIV),
      .DW(16)
   ) u_slow (
      .pclk(pclk),
      .presetn(presetn),
      .en(count_en),
      .tick(slow_tick)
   );

   wdt_prescaler #(
      .DIV(FAST_DIV),
      .DW(16)
   ) u_fast (
      .pclk(pclk),
      .presetn(presetn),
      .en(count_en),
      .tick(fast_tick)
   );

   // Bus phase decode
   always_comb begin
      setup = psel & ~penable;
      wr_acc = psel & penable & pready_q & pwrite;
      mode_wr = wr_acc & (paddr == OFF_MODE);
      key_wr = wr_acc & (paddr == OFF_KEY);
      bitop_wr = wr_acc & (paddr == OFF_KEY_BITOP);
      mapped = (paddr == OFF_MODE) | (paddr == OFF_KEY) |
               (paddr == OFF_KEY_BITOP) | (paddr == OFF_STATUS);
   end

   // Counting conditions
   always_comb begin
      parked = (lock_q == WDT_PARKED);
      run = ~mode_q.clock_sel_bit_four;
      hold = ~osc_unstoppable & (halt_mode | stop_mode);
      count_en = run & ~hold;
      // source from mode kept over sleep
      tick = mode_q.clock_sel_bit_three ? fast_tick : slow_tick;
      last = CNT_W'((CNT_W'(1) << (OVF_BASE + 5'(mode_q.ovf_sel))) - 1'b1);
   end

   // Mode lock, counter and reset request
   always_comb begin
      mode_d = mode_q;
      lock_d = lock_q;
      cnt_d = cnt_q;
      violation = 1'b0;
      overflow = 1'b0;

      if (mode_wr) begin
         if (lock_q == WDT_OPEN) begin
            mode_d = wdt_mode_t'(pwdata[7:0]);
            lock_d = pwdata[4] ? WDT_PARKED : WDT_LOCKED;
         end else if (!parked) begin
            violation = 1'b1;
         end
      end

      if (key_wr && pwdata[7:0] != KEY_CODE && !parked) begin
         violation = 1'b1;
      end

      if (bitop_wr && !parked) begin
         violation = 1'b1;
      end

      // count held, never cleared by sleep
      if (count_en && tick) begin
         // overflow raises reset in stop too when osc_unstoppable is set
         if (cnt_q == last) begin
            overflow = 1'b1;
            cnt_d = '0;
         end else begin
            cnt_d = cnt_q + 1'b1;
         end
      end

      if (key_wr && pwdata[7:0] == KEY_CODE) begin
         cnt_d = '0;
         // Clear wins over an overflow tick
         overflow = 1'b0;
      end

      rst_d = violation | overflow;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= wdt_mode_t'(MODE_RST);
         lock_q <= WDT_OPEN;
         cnt_q <= '0;
         rst_q <= 1'b0;
      end else begin
         mode_q <= mode_d;
         lock_q <= lock_d;
         cnt_q <= cnt_d;
         rst_q <= rst_d;
      end
   end

   // Read data and answer prepared in the setup cycle
   always_comb begin
      status = '0;
      status.lock = lock_q;
      status.counting = count_en;
      status.count = cnt_q;
      prdata_d = '0;
      pready_d = setup;
      pslverr_d = setup & ~mapped;
      if (setup && !pwrite) begin
         case (paddr)
            OFF_MODE: begin
               prdata_d = {24'h000000, mode_q};
            end
            OFF_KEY, OFF_KEY_BITOP: begin
               prdata_d = {24'h000000, KEY_READ};
            end
            OFF_STATUS: begin
               prdata_d = status;
            end
            default: begin
               prdata_d = '0;
            end
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= '0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign wdt_reset = rst_q;
endmodule : wdt_core

/* hdl/wdt_pkg.sv */
// Constants, types and register map of the watchdog timer core
package wdt_pkg;
   localparam int ADDR_W = 8;
   localparam int CNT_W = 20;

   // Byte addresses of the registers
   localparam logic [ADDR_W-1:0] OFF_MODE = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_KEY = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_KEY_BITOP = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;

   localparam logic [7:0] KEY_CODE = 8'hac;
   localparam logic [7:0] KEY_READ = 8'h9a;
   localparam logic [7:0] MODE_RST = 8'h67;

   // Overflow after 2^(OVF_BASE + select) ticks
   localparam logic [4:0] OVF_BASE = 5'h0c;

   // Tick periods of the two count sources
   localparam int CLK_PERIOD_NS = 10;
   localparam int SLOW_TICK_NS = 4000;
   localparam int FAST_TICK_NS = 100;
   localparam int SLOW_DIV = SLOW_TICK_NS / CLK_PERIOD_NS;
   localparam int FAST_DIV = FAST_TICK_NS / CLK_PERIOD_NS;

   typedef struct packed {
      logic [2:0] fixed;
      logic clock_sel_bit_four;
      logic clock_sel_bit_three;
      logic [2:0] ovf_sel;
   } wdt_mode_t;

   typedef enum logic [1:0] {
      WDT_OPEN = 2'b00,
      WDT_LOCKED = 2'b01,
      WDT_PARKED = 2'b10
   } wdt_lock_t;

   typedef struct packed {
      logic [8:0] zero;
      logic [1:0] lock;
      logic counting;
      logic [CNT_W-1:0] count;
   } wdt_status_t;
endpackage : wdt_pkg

/* hdl/wdt_prescaler.sv */
// Tick divider that holds its phase while disabled
`timescale 1ns/10ps
module wdt_prescaler #(
   parameter int DIV = 400,
   parameter int DW = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic en,
   output logic tick
);
   logic [DW-1:0] div_q;
   logic [DW-1:0] div_d;
   logic tick_q;
   logic tick_d;

   always_comb begin
      div_d = div_q;
      tick_d = 1'b0;
      if (en) begin
         if (div_q == DW'(DIV - 1)) begin
            div_d = '0;
            tick_d = 1'b1;
         end else begin
            div_d = div_q + 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= '0;
         tick_q <= 1'b0;
      end else begin
         div_q <= div_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;
endmodule : wdt_prescaler

/* verification/watchdog_timer_core_tb.sv */
// Self-checking bench of the watchdog timer core
`timescale 1ns/10ps
module watchdog_timer_core_tb;
   import wdt_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
   logic halt_mode = 0, stop_mode = 0, osc_unstoppable = 0, wdt_reset;
   logic [ADDR_W-1:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, rd, c;
   logic er;
   int fails = 0, checks = 0, hits = 0, n;
   int m_set = 0, m_park = 0;
   always #5 pclk = ~pclk;
   always @(posedge pclk) hits += (wdt_reset === 1'b1);
   wdt_core u_wdt_core (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .halt_mode(halt_mode),
      .stop_mode(stop_mode),
      .osc_unstoppable(osc_unstoppable),
      .wdt_reset(wdt_reset)
   );
   task automatic stop_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   task automatic chk(input string s, input logic [31:0] e, g);
      checks++;
      if (g !== e) begin
         fails++;
         $display("[FAIL] %s exp %h got %h", s, e, g);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk) penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 1, 0);
      if (n >= 20) stop_test();
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic hit(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [31:0] e);
      int em;
      em = 0;
      // Behavioural model of the reset causes
      if (a == OFF_MODE) begin
         if (m_set == 0) begin
            m_set = 1;
            m_park = d[4];
         end else if (m_park == 0) begin
            em = 1;
         end
      end else if (m_park == 0 && (a == OFF_KEY_BITOP || d != KEY_CODE)) begin
         em = 1;
      end
      apb(1'b1, a, d);
      @(posedge pclk);
      chk("resets", e, hits);
      chk("model", em, hits);
      hits = 0;
   endtask : hit
   task automatic rst(input logic u);
      presetn <= 1'b0;
      osc_unstoppable <= u;
      halt_mode <= 1'b0;
      stop_mode <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      hits = 0;
      m_set = 0;
      m_park = 0;
      @(posedge pclk);
   endtask : rst
   initial begin
      c = $urandom(99099);
      rst(1'b0);
      apb(1'b0, OFF_KEY, 0);
      chk("key read", KEY_READ, rd);
      chk("key err", 0, er);
      apb(1'b0, 8'h10, 0);
      chk("slverr", 1, er);
      chk("unmapped", 0, rd);
      repeat (2000) @(posedge pclk);
      hit(OFF_KEY, KEY_CODE, 0);
      apb(1'b0, OFF_STATUS, 0);
      chk("cleared", 1, rd[19:0] < 2);
      c = $urandom;
      rst(1'b0);
      hit(OFF_KEY, c[7:0] == KEY_CODE ? 8'h00 : c[7:0], 1);
      rst(1'b0);
      hit(OFF_KEY_BITOP, KEY_CODE, 1);
      rst(1'b0);
      hit(OFF_MODE, 8'h68, 0);
      apb(1'b0, OFF_MODE, 0);
      chk("mode", 32'h68, rd);
      hit(OFF_MODE, 8'h68, 1);
      rst(1'b0);
      hit(OFF_MODE, 8'h70, 0);
      hit(OFF_MODE, 8'h68, 0);
      hit(OFF_KEY, 8'h11, 0);
      hit(OFF_KEY_BITOP, 8'h11, 0);
      rst(1'b0);
      hit(OFF_MODE, 8'h68, 0);
      repeat (300) @(posedge pclk);
      halt_mode <= 1'b1;
      repeat (300) @(posedge pclk);
      apb(1'b0, OFF_STATUS, 0);
      c = rd;
      chk("halted", 0, c[20]);
      repeat (300) @(posedge pclk);
      apb(1'b0, OFF_STATUS, 0);
      chk("frozen", c, rd);
      halt_mode <= 1'b0;
      repeat (300) @(posedge pclk);
      apb(1'b0, OFF_STATUS, 0);
      chk("resumed", 1, rd[19:0] - c[19:0] inside {[29:32]});
      rst(1'b1);
      hit(OFF_MODE, 8'h68, 0);
      stop_mode <= 1'b1;
      repeat (30000) @(posedge pclk);
      stop_mode <= 1'b0;
      hit(OFF_KEY, KEY_CODE, 0);
      stop_mode <= 1'b1;
      for (n = 0; n < 45000 && hits == 0; n++) @(posedge pclk);
      chk("overflow", 1, hits == 1 && n > 40000);
      stop_test();
   end
endmodule : watchdog_timer_core_tb

/* verification/wdt_core_monitor.sv */
// Port checks of the watchdog timer core
`timescale 1ns/10ps
module wdt_core_monitor import wdt_pkg::*; (
   input logic pclk,
   input logic presetn,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [wdt_pkg::ADDR_W-1:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input logic halt_mode,
   input logic stop_mode,
   input logic osc_unstoppable,
   input logic wdt_reset
);
   logic wr, set_q, park_q;
   assign wr = psel && penable && pready && pwrite && !park_q;
   // First mode write decides
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         set_q <= 1'b0;
         park_q <= 1'b0;
      end else if (wr && paddr == OFF_MODE && !set_q) begin
         set_q <= 1'b1;
         park_q <= pwdata[4];
      end
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_krd; pready && !pwrite && paddr == OFF_KEY |-> prdata[7:0] == KEY_READ; endproperty
   a_krd: assert property (p_krd) else $error("key read");
   property p_bad; wr && paddr == OFF_KEY && pwdata[7:0] != KEY_CODE |=> wdt_reset; endproperty
   a_bad: assert property (p_bad) else $error("bad key");
   property p_bit; wr && paddr == OFF_KEY_BITOP |=> wdt_reset; endproperty
   a_bit: assert property (p_bit) else $error("bit op");
   property p_two; wr && paddr == OFF_MODE && set_q |=> wdt_reset; endproperty
   a_two: assert property (p_two) else $error("mode twice");
   property p_ok; wr && paddr == OFF_KEY && pwdata[7:0] == KEY_CODE |=> !wdt_reset; endproperty
   a_ok: assert property (p_ok) else $error("good key");
   property p_one; wdt_reset |=> !wdt_reset; endproperty
   a_one: assert property (p_one) else $error("long pulse");
   property p_frz; (!osc_unstoppable && (halt_mode || stop_mode) && !psel) [*2] |-> !wdt_reset;
   endproperty
   a_frz: assert property (p_frz) else $error("not frozen");
   c_key: cover property (wr && paddr == OFF_KEY);
   c_rst: cover property (wdt_reset);
   c_frz: cover property (halt_mode && !osc_unstoppable);
endmodule : wdt_core_monitor
bind wdt_core wdt_core_monitor u_wdt_core_monitor (.*);
